/* File: hcm_map.svh */
// Register offsets, field positions, reset values and limits of the heater current monitor
`ifndef HCM_MAP_SVH
`define HCM_MAP_SVH
`define HCM_OFF_CTRL    8'h00
`define HCM_OFF_SP_LOW  8'h04
`define HCM_OFF_SP_HIGH 8'h08
`define HCM_OFF_SP_TRIP 8'h0c
`define HCM_OFF_PLIM    8'h10
`define HCM_OFF_ALARM   8'h14
`define HCM_OFF_INT_ST  8'h18
`define HCM_OFF_INT_MSK 8'h1c
`define HCM_OFF_MEAS    8'h20
`define HCM_CTRL_3PH    0
`define HCM_CTRL_PROP   1
`define HCM_CTRL_PLIM   2
`define HCM_CTRL_R100   3
`define HCM_ALM_LOW     0
`define HCM_ALM_HIGH    3
`define HCM_ALM_TRIP    6
`define HCM_SP_OFF      8'h00
`define HCM_MAX_30A     8'h3c
`define HCM_MAX_100A    8'hc8
`define HCM_DUTY_FULL   9'h100
`define HCM_AVG_SHIFT   4
`define HCM_RST_CTRL    4'h0
`define HCM_RST_SP      24'h000000
`define HCM_RST_ALM     9'h000
`define HCM_RESP_OK     2'h0
`define HCM_RESP_ERR    2'h2
`endif

/* File: hcm_monitor.sv */
// Heater current alarm and trip monitor with AXI4-Lite registers
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "hcm_map.svh"
module hcm_monitor (
    input  wire logic             sys_clk_in,
    input  wire logic             arst_n_in,
    input  wire logic             ce_in,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire hcm_pkg::hcm_addr_t s_axi_awaddr,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    output logic [1:0]            s_axi_bresp,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    input  wire hcm_pkg::hcm_addr_t s_axi_araddr,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    input  wire logic             meas_valid_in,
    input  wire hcm_pkg::hcm_cur_t cur_a_in,
    input  wire hcm_pkg::hcm_cur_t cur_b_in,
    input  wire hcm_pkg::hcm_cur_t cur_c_in,
    input  wire hcm_pkg::hcm_duty_t duty_in,
    input  wire logic             heat_demand_in,
    output logic                  heater_on_out,
    output hcm_pkg::hcm_alarm_t   alarm_out,
    output logic                  irq_out
);
    import hcm_pkg::*;
    logic        awready_ff;
    logic        wready_ff;
    logic        bvalid_ff;
    logic [1:0]  bresp_ff;
    logic        arready_ff;
    logic        rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0]  rresp_ff;
    hcm_addr_t   awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0]  wstrb_ff;
    logic [3:0]  ctrl_ff;
    logic [23:0] sp_low_ff;
    logic [23:0] sp_high_ff;
    logic [23:0] sp_trip_ff;
    hcm_cur_t    plim_ff;
    hcm_alarm_t  alarm_ff;
    hcm_alarm_t  int_st_ff;
    hcm_alarm_t  int_msk_ff;
    logic [23:0] meas_ff;
    logic [11:0] avg_ff;
    logic        heater_on_ff;
    logic        irq_ff;
    hcm_alarm_t  nxt_alarm;
    hcm_alarm_t  nxt_int_st;
    logic [11:0] nxt_avg;
    logic        nxt_heater_on;
    logic        wr_go;
    logic        wr_map;
    logic        rd_map;
    logic [31:0] rd_mux;
    logic [8:0]  trip_clr;
    hcm_cur_t    sp_max;
    logic        scale_on;
    hcm_duty_t   duty_eff;
    logic        below_full;
    logic        plim_over;
    logic [2:0]  lo_hit;
    logic [2:0]  hi_hit;
    logic [2:0]  tr_hit;
    logic [23:0] cur_all;
    assign s_axi_awready = awready_ff;
    assign s_axi_wready  = wready_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;
    assign heater_on_out = heater_on_ff;
    assign alarm_out     = alarm_ff;
    assign irq_out       = irq_ff;
    // Byte-lane merge, each setpoint byte then clamped to the rated range
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return res;
    endfunction
    function automatic logic [23:0] clamp_sp(input logic [23:0] v, input hcm_cur_t mx);
        logic [23:0] res;
        res = v;
        for (int i = 0; i < 3; i++)
        begin
            if (v[8*i +: 8] > mx)
            begin
                res[8*i +: 8] = mx;
            end
        end
        return res;
    endfunction

    // Write channel: address and data taken in either order, response after both
    assign wr_go = !awready_ff && !wready_ff && !bvalid_ff;
    always_comb
    begin
        case (awaddr_ff)
            `HCM_OFF_CTRL, `HCM_OFF_SP_LOW, `HCM_OFF_SP_HIGH, `HCM_OFF_SP_TRIP,
            `HCM_OFF_PLIM, `HCM_OFF_ALARM, `HCM_OFF_INT_ST, `HCM_OFF_INT_MSK,
            `HCM_OFF_MEAS: wr_map = 1'b1;
            default:       wr_map = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            awready_ff <= 1'b1;
            wready_ff  <= 1'b1;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= `HCM_RESP_OK;
            awaddr_ff  <= 8'h00;
            wdata_ff   <= 32'h00000000;
            wstrb_ff   <= 4'h0;
        end
        else if (ce_in)
        begin
            if (awready_ff && s_axi_awvalid)
            begin
                awready_ff <= 1'b0;
                awaddr_ff  <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (wready_ff && s_axi_wvalid)
            begin
                wready_ff <= 1'b0;
                wdata_ff  <= s_axi_wdata;
                wstrb_ff  <= s_axi_wstrb;
            end
            if (wr_go)
            begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= wr_map ? `HCM_RESP_OK : `HCM_RESP_ERR;
            end
            if (bvalid_ff && s_axi_bready)
            begin
                bvalid_ff  <= 1'b0;
                awready_ff <= 1'b1;
                wready_ff  <= 1'b1;
            end
        end
    end

    // Setpoint and control registers
    assign sp_max = ctrl_ff[`HCM_CTRL_R100] ? `HCM_MAX_100A : `HCM_MAX_30A;
    always_ff @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            ctrl_ff    <= `HCM_RST_CTRL;
            sp_low_ff  <= `HCM_RST_SP;
            sp_high_ff <= `HCM_RST_SP;
            sp_trip_ff <= `HCM_RST_SP;
            plim_ff    <= `HCM_SP_OFF;
            int_msk_ff <= `HCM_RST_ALM;
        end
        else if (ce_in && wr_go)
        begin
            case (awaddr_ff)
                `HCM_OFF_CTRL:    ctrl_ff    <= 4'(merge({28'h0, ctrl_ff}, wdata_ff, wstrb_ff));
                `HCM_OFF_SP_LOW:  sp_low_ff  <= clamp_sp(24'(merge({8'h00, sp_low_ff}, wdata_ff,
                                                         wstrb_ff)), sp_max);
                `HCM_OFF_SP_HIGH: sp_high_ff <= clamp_sp(24'(merge({8'h00, sp_high_ff}, wdata_ff,
                                                         wstrb_ff)), sp_max);
                `HCM_OFF_SP_TRIP: sp_trip_ff <= clamp_sp(24'(merge({8'h00, sp_trip_ff}, wdata_ff,
                                                         wstrb_ff)), sp_max);
                `HCM_OFF_PLIM:    plim_ff    <= 8'(clamp_sp({16'h0000, 8'(merge({24'h0, plim_ff}, wdata_ff,
                                                wstrb_ff))}, sp_max));
                `HCM_OFF_INT_MSK: int_msk_ff <= 9'(merge({23'h0, int_msk_ff}, wdata_ff, wstrb_ff));
                default:          ctrl_ff    <= ctrl_ff;
            endcase
        end
    end

    // Operator reset of trips and write-one-clear of interrupt status
    always_comb
    begin
        trip_clr   = 9'h000;
        nxt_int_st = int_st_ff;
        if (wr_go && awaddr_ff == `HCM_OFF_ALARM)
        begin
            trip_clr = 9'(merge(32'h0, wdata_ff, wstrb_ff));
        end
        if (wr_go && awaddr_ff == `HCM_OFF_INT_ST)
        begin
            nxt_int_st = int_st_ff & ~9'(merge(32'h0, wdata_ff, wstrb_ff));
        end
        nxt_int_st = nxt_int_st | (nxt_alarm & ~alarm_ff);
    end

    // Scaling: reading*256 compared with setpoint*duty avoids a divider
    assign scale_on   = ctrl_ff[`HCM_CTRL_PROP] || ctrl_ff[`HCM_CTRL_PLIM];
    assign duty_eff   = (!scale_on || duty_in > `HCM_DUTY_FULL) ? `HCM_DUTY_FULL : duty_in;
    assign below_full = scale_on && duty_in < `HCM_DUTY_FULL;
    assign cur_all    = {cur_c_in, cur_b_in, cur_a_in};

    for (genvar p = 0; p < 3; p++)
    begin : g_phase
        hcm_cur_t  cur;
        hcm_prod_t lhs;
        logic      act;
        assign cur = cur_all[8*p +: 8];
        assign lhs = {1'b0, cur, 8'h00};
        assign act = (p == 0) || ctrl_ff[`HCM_CTRL_3PH];
        assign lo_hit[p] = act && duty_eff != 9'h000 && sp_low_ff[8*p +: 8] != `HCM_SP_OFF &&
                           lhs <= hcm_prod_t'(sp_low_ff[8*p +: 8] * duty_eff);
        assign hi_hit[p] = act && !below_full && sp_high_ff[8*p +: 8] != `HCM_SP_OFF &&
                           cur >= sp_high_ff[8*p +: 8];
        assign tr_hit[p] = act && duty_eff != 9'h000 && sp_trip_ff[8*p +: 8] != `HCM_SP_OFF &&
                           lhs >= hcm_prod_t'(sp_trip_ff[8*p +: 8] * duty_eff);
    end

    // Alarms follow each sample; trips latch and a new trip beats a reset
    always_comb
    begin
        nxt_alarm = alarm_ff;
        if (meas_valid_in)
        begin
            nxt_alarm[`HCM_ALM_LOW +: 3]  = lo_hit;
            nxt_alarm[`HCM_ALM_HIGH +: 3] = hi_hit;
        end
        nxt_alarm[`HCM_ALM_TRIP +: 3] = (alarm_ff[`HCM_ALM_TRIP +: 3] &
                                         ~trip_clr[`HCM_ALM_TRIP +: 3]) |
                                        (meas_valid_in ? tr_hit : 3'b000);
    end

    // Average current for the power limit
    assign nxt_avg   = meas_valid_in ? avg_ff - {4'h0, avg_ff[11:`HCM_AVG_SHIFT]} + {4'h0, cur_a_in}
                                     : avg_ff;
    assign plim_over = ctrl_ff[`HCM_CTRL_PLIM] && plim_ff != `HCM_SP_OFF &&
                       avg_ff >= {plim_ff, 4'h0};
    assign nxt_heater_on = heat_demand_in && !plim_over &&
                           nxt_alarm[`HCM_ALM_TRIP +: 3] == 3'b000;

    always_ff @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            alarm_ff     <= `HCM_RST_ALM;
            int_st_ff    <= `HCM_RST_ALM;
            irq_ff       <= 1'b0;
            avg_ff       <= 12'h000;
            meas_ff      <= 24'h000000;
            heater_on_ff <= 1'b0;
        end
        else if (ce_in)
        begin
            alarm_ff     <= nxt_alarm;
            int_st_ff    <= nxt_int_st;
            irq_ff       <= |(nxt_int_st & int_msk_ff);
            avg_ff       <= nxt_avg;
            heater_on_ff <= nxt_heater_on;
            if (meas_valid_in)
            begin
                meas_ff <= cur_all;
            end
        end
    end

    // Read channel: data one cycle after the address is taken
    always_comb
    begin
        rd_map = 1'b1;
        case ({s_axi_araddr[7:2], 2'b00})
            `HCM_OFF_CTRL:    rd_mux = {28'h0, ctrl_ff};
            `HCM_OFF_SP_LOW:  rd_mux = {8'h00, sp_low_ff};
            `HCM_OFF_SP_HIGH: rd_mux = {8'h00, sp_high_ff};
            `HCM_OFF_SP_TRIP: rd_mux = {8'h00, sp_trip_ff};
            `HCM_OFF_PLIM:    rd_mux = {24'h0, plim_ff};
            `HCM_OFF_ALARM:   rd_mux = {23'h0, alarm_ff};
            `HCM_OFF_INT_ST:  rd_mux = {23'h0, int_st_ff};
            `HCM_OFF_INT_MSK: rd_mux = {23'h0, int_msk_ff};
            `HCM_OFF_MEAS:    rd_mux = {8'h00, meas_ff};
            default:
            begin
                rd_mux = 32'h00000000;
                rd_map = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h00000000;
            rresp_ff   <= `HCM_RESP_OK;
        end
        else if (ce_in)
        begin
            if (arready_ff && s_axi_arvalid)
            begin
                arready_ff <= 1'b0;
                rvalid_ff  <= 1'b1;
                rdata_ff   <= rd_mux;
                rresp_ff   <= rd_map ? `HCM_RESP_OK : `HCM_RESP_ERR;
            end
            else if (rvalid_ff && s_axi_rready)
            begin
                rvalid_ff  <= 1'b0;
                arready_ff <= 1'b1;
            end
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!arst_n_in);
    sequence s_trip_seen;
        ce_in && meas_valid_in && tr_hit[0];
    endsequence
    sequence s_open_held;
        !heater_on_ff && alarm_ff[`HCM_ALM_TRIP];
    endsequence
    low_set_a: assert property (ce_in && meas_valid_in && lo_hit[0] |=> alarm_ff[`HCM_ALM_LOW])
        else $error("low alarm not raised");
    low_clear_a: assert property (ce_in && meas_valid_in && !lo_hit[0] |=> !alarm_ff[`HCM_ALM_LOW])
        else $error("low alarm not cleared");
    off_silent_a: assert property (ce_in && meas_valid_in && sp_trip_ff[7:0] == `HCM_SP_OFF
                                   && !alarm_ff[`HCM_ALM_TRIP] |=> !alarm_ff[`HCM_ALM_TRIP])
        else $error("off setpoint raised a trip");
    high_set_a: assert property (ce_in && meas_valid_in && !below_full && sp_high_ff[7:0] != 8'h00
                                 && cur_a_in >= sp_high_ff[7:0] |=> alarm_ff[`HCM_ALM_HIGH])
        else $error("high alarm not raised");
    high_clear_a: assert property (ce_in && meas_valid_in && cur_a_in < sp_high_ff[7:0]
                                   |=> !alarm_ff[`HCM_ALM_HIGH])
        else $error("high alarm not cleared");
    high_supp_a: assert property (ce_in && meas_valid_in && below_full
                                  |=> alarm_ff[`HCM_ALM_HIGH +: 3] == 3'b000)
        else $error("high alarm below full duty");
    trip_open_a: assert property (s_trip_seen |=> s_open_held)
        else $error("trip did not open heater");
    trip_hold_a: assert property (alarm_ff[`HCM_ALM_TRIP] && !(wr_go && awaddr_ff == `HCM_OFF_ALARM)
                                  |=> alarm_ff[`HCM_ALM_TRIP])
        else $error("trip dropped without reset");
    phase_off_a: assert property (!ctrl_ff[`HCM_CTRL_3PH] |-> tr_hit[2:1] == 2'b00)
        else $error("phase B or C checked in single phase");
    sp_range_a: assert property (sp_low_ff[7:0] <= `HCM_MAX_100A && sp_trip_ff[23:16] <= `HCM_MAX_100A)
        else $error("setpoint above range");
    plim_gate_a: assert property (ce_in && plim_over |=> !heater_on_ff)
        else $error("power limit not enforced");
    trip_force_a: assert property (ce_in && |alarm_ff[`HCM_ALM_TRIP +: 3] && !(|trip_clr)
                                   |=> !heater_on_ff)
        else $error("heater on with trip latched");
endmodule // hcm_monitor

/* File: hcm_monitor_tb_top.sv */
// Self-checking bench for the heater current monitor
`timescale 1ns/1ps
`include "hcm_map.svh"
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("Error %s exp %0h got %0h", n, e, g); end end
module hcm_monitor_tb_top;
    import hcm_pkg::*;
    logic        clk = 0, rst_n = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, go = 0;
    logic        awr, wrd, bv, arr, rv, mv, htr, irq;
    hcm_addr_t   awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rdat, v;
    logic [3:0]  ws = 4'h0;
    logic [1:0]  br, rr, bq, rq;
    hcm_cur_t    ca = 8'h00, cb = 8'h00, cc = 8'h00, ma, mb, mc;
    hcm_duty_t   du = 9'h100, md;
    hcm_alarm_t  alm;
    int          n_mismatch = 0, n_checks = 0;
    initial
    begin
        forever #25 clk = ~clk;
    end
    hcm_monitor dut (.sys_clk_in(clk), .arst_n_in(rst_n), .ce_in(1'b1), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_wdata(wd), .s_axi_wstrb(ws),
        .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rry), .s_axi_rdata(rdat), .s_axi_rresp(rr),
        .meas_valid_in(mv), .cur_a_in(ma), .cur_b_in(mb), .cur_c_in(mc), .duty_in(md), .heat_demand_in(1'b1),
        .heater_on_out(htr), .alarm_out(alm), .irq_out(irq));
    hcm_sense_model model (.sys_clk_in(clk), .arst_n_in(rst_n), .go_in(go), .a_in(ca), .b_in(cb), .c_in(cc),
        .duty_in(du), .meas_valid_out(mv), .cur_a_out(ma), .cur_b_out(mb), .cur_c_out(mc), .duty_out(md));
    task automatic wr(input hcm_addr_t a, input logic [31:0] d, input logic [3:0] s);
        int   t;
        logic ta, tw;
        t = 0;
        ta = 0;
        tw = 0;
        @(posedge clk);
        awa <= a;
        wd <= d;
        ws <= s;
        awv <= 1'b1;
        wv <= 1'b1;
        while (!(ta && tw) && t < 99)
        begin
            @(posedge clk);
            t++;
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
            ta |= awr;
            tw |= wrd;
        end
        bry <= 1'b1;
        do @(posedge clk); while (bv !== 1'b1 && ++t < 99);
        if (t >= 99) n_mismatch++;
        bq = br;
        bry <= 1'b0;
    endtask
    task automatic rd(input hcm_addr_t a);
        int t;
        t = 0;
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        do @(posedge clk); while (arr !== 1'b1 && ++t < 99);
        arv <= 1'b0;
        do @(posedge clk); while (rv !== 1'b1 && ++t < 99);
        if (t >= 99) n_mismatch++;
        v = rdat;
        rq = rr;
        rry <= 1'b0;
    endtask
    task automatic sm(input hcm_cur_t a, input hcm_cur_t b, input hcm_cur_t c, input hcm_duty_t d);
        @(posedge clk);
        ca <= a;
        cb <= b;
        cc <= c;
        du <= d;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic sc(input hcm_cur_t a, input hcm_cur_t b, input hcm_cur_t c, input hcm_duty_t d,
                      input hcm_alarm_t ea, input logic eh);
        sm(a, b, c, d);
        `CHK("alarm", ea, alm)
        `CHK("heater", eh, htr)
    endtask
    task automatic ck_irq(input logic e);
        repeat (2) @(posedge clk);
        `CHK("irq", e, irq)
    endtask
    task t_rst;
        `CHK("alarm", 9'h000, alm)
        rd(`HCM_OFF_SP_TRIP);
        `CHK("sp_trip", 32'h0, v)
        rd(`HCM_OFF_SP_LOW);
        `CHK("sp_low", 32'h0, v)
        sc(8'h00, 8'h00, 8'h00, 9'h100, 9'h000, 1'b1);
    endtask
    task t_levels;
        wr(`HCM_OFF_SP_LOW, 32'h14, 4'hf);
        sc(8'h14, 8'h00, 8'h00, 9'h100, 9'h001, 1'b1);
        sc(8'h15, 8'h00, 8'h00, 9'h100, 9'h000, 1'b1);
        wr(`HCM_OFF_SP_HIGH, 32'h28, 4'hf);
        sc(8'h28, 8'h00, 8'h00, 9'h100, 9'h008, 1'b1);
        sc(8'h27, 8'h00, 8'h00, 9'h100, 9'h000, 1'b1);
    endtask
    task t_trip;
        wr(`HCM_OFF_SP_TRIP, 32'h32, 4'hf);
        sc(8'h32, 8'h00, 8'h00, 9'h100, 9'h048, 1'b0);
        sc(8'h1e, 8'h00, 8'h00, 9'h100, 9'h040, 1'b0);
        wr(`HCM_OFF_ALARM, 32'h40, 4'hf);
        sc(8'h1e, 8'h00, 8'h00, 9'h100, 9'h000, 1'b1);
    endtask
    task t_3ph;
        wr(`HCM_OFF_SP_LOW, 32'h0a0a14, 4'hf);
        sc(8'h1e, 8'h05, 8'h05, 9'h100, 9'h000, 1'b1);
        wr(`HCM_OFF_CTRL, 32'h1, 4'hf);
        sc(8'h1e, 8'h05, 8'h0b, 9'h100, 9'h002, 1'b1);
        rd(`HCM_OFF_MEAS);
        `CHK("meas", 32'h000b051e, v)
        wr(`HCM_OFF_SP_LOW, 32'h0c0000, 4'h4);
        sc(8'h1e, 8'h0b, 8'h0b, 9'h100, 9'h004, 1'b1);
        wr(`HCM_OFF_CTRL, 32'h0, 4'hf);
    endtask
    task t_scale;
        wr(`HCM_OFF_CTRL, 32'h2, 4'hf);
        wr(`HCM_OFF_SP_HIGH, 32'h1e, 4'hf);
        sc(8'h0a, 8'h00, 8'h00, 9'h080, 9'h001, 1'b1);
        sc(8'h0b, 8'h00, 8'h00, 9'h080, 9'h000, 1'b1);
        sc(8'h1e, 8'h00, 8'h00, 9'h0c0, 9'h000, 1'b1);
        sc(8'h1e, 8'h00, 8'h00, 9'h100, 9'h008, 1'b1);
        sc(8'h19, 8'h00, 8'h00, 9'h080, 9'h040, 1'b0);
        wr(`HCM_OFF_ALARM, 32'h40, 4'hf);
        wr(`HCM_OFF_CTRL, 32'h0, 4'hf);
    endtask
    task t_clamp;
        wr(`HCM_OFF_SP_TRIP, 32'hff, 4'h1);
        rd(`HCM_OFF_SP_TRIP);
        `CHK("sp_trip", 32'h3c, v)
        wr(`HCM_OFF_CTRL, 32'h8, 4'hf);
        wr(`HCM_OFF_SP_TRIP, 32'hff, 4'h1);
        rd(`HCM_OFF_SP_TRIP);
        `CHK("sp_trip", 32'hc8, v)
        wr(`HCM_OFF_CTRL, 32'h0, 4'hf);
    endtask
    task t_plim;
        wr(`HCM_OFF_PLIM, 32'h3c, 4'hf);
        wr(`HCM_OFF_CTRL, 32'h4, 4'hf);
        sc(8'h14, 8'h00, 8'h00, 9'h100, 9'h001, 1'b1);
        repeat (40) sm(8'h50, 8'h00, 8'h00, 9'h100);
        `CHK("heater", 1'b0, htr)
        wr(`HCM_OFF_CTRL, 32'h0, 4'hf);
        sc(8'h14, 8'h00, 8'h00, 9'h100, 9'h001, 1'b1);
    endtask
    task t_irq;
        sm(8'h1e, 8'h00, 8'h00, 9'h100);
        wr(`HCM_OFF_INT_ST, 32'h1ff, 4'hf);
        wr(`HCM_OFF_INT_MSK, 32'h1, 4'hf);
        `CHK("bresp", `HCM_RESP_OK, bq)
        ck_irq(1'b0);
        sm(8'h0a, 8'h00, 8'h00, 9'h100);
        ck_irq(1'b1);
        wr(`HCM_OFF_INT_MSK, 32'h0, 4'hf);
        ck_irq(1'b0);
        rd(`HCM_OFF_INT_ST);
        `CHK("int_st", 1'b1, v[0])
        wr(`HCM_OFF_INT_MSK, 32'h1, 4'hf);
        ck_irq(1'b1);
        wr(`HCM_OFF_INT_ST, 32'h1, 4'hf);
        ck_irq(1'b0);
    endtask
    task t_bus;
        wr(8'h3c, 32'h1, 4'hf);
        `CHK("bresp", `HCM_RESP_ERR, bq)
        rd(8'h3c);
        `CHK("rresp", `HCM_RESP_ERR, rq)
        `CHK("rdata", 32'h0, v)
    endtask
    task final_report;
        $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_rst;
        t_levels;
        t_trip;
        t_3ph;
        t_scale;
        t_clamp;
        t_plim;
        t_irq;
        t_bus;
        final_report;
    end
    initial
    begin
        #(50 * 20000);
        n_mismatch++;
        final_report;
    end
endmodule // hcm_monitor_tb_top

/* File: hcm_pkg.sv */
// Types shared by the heater current monitor
package hcm_pkg;
    typedef logic [7:0]  hcm_cur_t;
    typedef logic [8:0]  hcm_duty_t;
    typedef logic [8:0]  hcm_alarm_t;
    typedef logic [7:0]  hcm_addr_t;
    typedef logic [16:0] hcm_prod_t;
endpackage

/* File: hcm_sense_model.sv */
// Behavioural current sensing front end that feeds samples to the monitor
`timescale 1ns/1ps
module hcm_sense_model (
    input  wire logic              sys_clk_in,
    input  wire logic              arst_n_in,
    input  wire logic              go_in,
    input  wire hcm_pkg::hcm_cur_t a_in,
    input  wire hcm_pkg::hcm_cur_t b_in,
    input  wire hcm_pkg::hcm_cur_t c_in,
    input  wire hcm_pkg::hcm_duty_t duty_in,
    output logic                   meas_valid_out,
    output hcm_pkg::hcm_cur_t      cur_a_out,
    output hcm_pkg::hcm_cur_t      cur_b_out,
    output hcm_pkg::hcm_cur_t      cur_c_out,
    output hcm_pkg::hcm_duty_t     duty_out
);
    import hcm_pkg::*;
    // One pulse per sample; lines scramble between samples
    always_ff @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            meas_valid_out <= 1'b0;
            cur_a_out      <= 8'h00;
            cur_b_out      <= 8'h00;
            cur_c_out      <= 8'h00;
            duty_out       <= 9'h000;
        end
        else
        begin
            meas_valid_out <= go_in;
            cur_a_out      <= go_in ? a_in : ~cur_a_out;
            cur_b_out      <= go_in ? b_in : ~cur_b_out;
            cur_c_out      <= go_in ? c_in : ~cur_c_out;
            duty_out       <= go_in ? duty_in : ~duty_out;
        end
    end
endmodule // hcm_sense_model
